// ### inc/mcb_defs.svh
/*
 * mcb_defs.svh: offsets, field positions, reset values and cycle
 * counts of the instruction execution block.
 * assumes: included by bare name from the design files.
 */
`ifndef MCB_DEFS_SVH
`define MCB_DEFS_SVH

`define MCB_RST_PC     12'h000
`define MCB_PTR_BASE   8'h80
`define MCB_STK_DEPTH  6
`define MCB_STK_LAST   3'h5
`define MCB_REL_BIAS   12'h001
`define MCB_BT_BIAS    12'h002
`define MCB_F_PTRSEL   4
`define MCB_F_BITSET   4
`define MCB_F_MODE     3
`define MCB_CYC_CTRL   2
`define MCB_CYC_ALU    4
`define MCB_CYC_BT     5
`define MCB_INH_NOP    4'h0
`define MCB_INH_RET    4'h1
`define MCB_INH_RETURN_FROM_INTERRUPT   4'h2
`define MCB_INH_STOP   4'h3
`define MCB_INH_WAIT   4'h4
`define MCB_INH_COM    4'h5
`define MCB_INH_RLC    4'h6
`define MCB_INH_SLA    4'h7

`endif

// ### inc/mcb_pkg.sv
/*
 * mcb_pkg: state, instruction class and ALU operation types.
 * assumes: nothing beyond the compile order.
 */
package mcb_pkg;
   typedef enum logic [5:0] {
      S_FETCH = 6'h01,
      S_BYTE2 = 6'h02,
      S_OPER  = 6'h04,
      S_BYTE3 = 6'h08,
      S_EXEC  = 6'h10,
      S_HALT  = 6'h20
   } mcb_state_t;

   typedef enum logic [2:0] {
      CL_REL, CL_BT, CL_BIT, CL_JMP, CL_ALU, CL_INH, CL_SD, CL_NOP
   } mcb_class_t;

   typedef enum logic [3:0] {
      A_ADD, A_AND, A_SUB, A_INC, A_DEC, A_COM, A_RLC, A_SLA, A_PASS
   } mcb_aluop_t;
endpackage

// ### src/mcb_alu.sv
/*
 * mcb_alu: combinational 8-bit accumulator arithmetic and logic.
 * assumes: a is the accumulator, b the second operand; cin is the
 * current carry, passed through where carry is left alone.
 */
module mcb_alu
   import mcb_pkg::*;
(
   input  wire mcb_aluop_t op,
   input  wire logic [7:0] a,
   input  wire logic [7:0] b,
   input  wire logic       cin,
   output logic      [7:0] y,
   output logic            z,
   output logic            c
);
   logic [8:0] wide;

   always_comb begin
      wide = 9'h000;
      y    = a;
      c    = cin;
      case (op)
         A_ADD: begin
            wide = {1'b0, a} + {1'b0, b};
            y    = wide[7:0];
            c    = wide[8];
         end
         A_AND: begin
            y = a & b;
            c = 1'b0;
         end
         A_SUB: begin
            // carry reads as borrow
            wide = {1'b0, a} - {1'b0, b};
            y    = wide[7:0];
            c    = wide[8];
         end
         A_INC: y = b + 8'h01;
         A_DEC: y = b - 8'h01;
         A_COM: begin
            y = ~a;
            c = a[7];
         end
         A_RLC: begin
            y = {a[6:0], cin};
            c = a[7];
         end
         A_SLA: begin
            y = {a[6:0], 1'b0};
            c = a[7];
         end
         default: y = b;
      endcase
      z = (y == 8'h00);
   end
endmodule

// ### src/mcb_exec_unit.sv
/*
 * mcb_exec_unit: fetch and execution of the arithmetic, branch, bit
 * and control instructions of the 8-bit core, with flags and stack.
 * assumes: program memory and data space answer combinationally in
 * the cycle the address is shown; pins wdgOption, wakeReq and irqReq
 * are asynchronous, irqVector is stable on this clock.
 */
// Notes on behaviour
// - add, and, compare and subtract use the accumulator and a data byte or an immediate.
// - invert, rotate through carry and shift left touch only the accumulator and set Z and C.
// - the four short branches test C set, C clear, Z set, Z clear in one byte, two cycles, flags kept.
// - the short branch displacement is 5-bit signed, reaching -15 to +16 from the branch.
// - bit test branches take an 8-bit signed displacement reaching -126 to +129.
// - branch_if_bit_clear jumps on a 0 bit, is 3 bytes and 5 cycles, copies the bit to C, keeps Z.
// - branch_if_bit_set jumps on a 1 bit, with the same length, timing and carry copy.
// - bit operations reach every bit of every data space byte.
// - bit set and bit_clear_op pick the bit by 3 bits, are 2 bytes, 4 cycles, flags kept.
// - long_jump and call carry a 12-bit target over the whole program space.
// - with the watchdog option a stop acts as wait; control ops are 1 byte, 2 cycles.
// - control ops steer run, wait and stop; only return_from_interrupt alters Z and C.
// - register-indirect ops pick pointer X or Y by opcode bit 4 and are one byte.
// - pointers and short-direct registers sit at 80h to 83h, reached in one byte.
module mcb_exec_unit
   import mcb_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        nrst,
   output logic      [11:0] pmAddr,
   input  wire logic [7:0]  pmData,
   output logic      [7:0]  dsAddr,
   input  wire logic [7:0]  dsRdData,
   output logic      [7:0]  dsWrData,
   output logic             dsWe,
   input  wire logic        wdgOption,
   input  wire logic        wakeReq,
   input  wire logic        irqReq,
   input  wire logic [11:0] irqVector,
   output logic      [7:0]  accOut,
   output logic             flagZ,
   output logic             flagC,
   output logic             stopMode,
   output logic             waitMode,
   output logic             inIrq
);
`include "mcb_defs.svh"

   mcb_state_t state;
   mcb_class_t cls;
   mcb_class_t fetchCls;
   mcb_aluop_t aluOp;
   logic [2:0]  syncMeta;
   logic [2:0]  syncOut;
   logic        wdgS;
   logic        wakeS;
   logic        irqS;
   logic [11:0] pc;
   logic [11:0] instrPc;
   logic [11:0] stk [0:`MCB_STK_DEPTH-1];
   logic [2:0]  sp;
   logic [2:0]  spDec;
   logic [7:0]  opcode;
   logic [7:0]  byte2;
   logic [7:0]  byte3;
   logic [7:0]  acc;
   logic        tbit;
   logic        resZ;
   logic        resC;
   logic        savedZ;
   logic        savedC;
   logic        irqTake;
   logic        isImm;
   logic        isIncDec;
   logic        btTaken;
   logic [2:0]  bitSel;
   logic [7:0]  bitMask;
   logic [7:0]  aluB;
   logic [7:0]  aluY;
   logic        aluZ;
   logic        aluC;
   logic [11:0] sext5;
   logic [11:0] sext8;
   logic [11:0] jmpTgt;

   function automatic mcb_class_t classOf(input logic [7:0] op);
      if (!op[0])
         classOf = CL_REL;
      else if (op[2:0] == 3'h3)
         classOf = op[`MCB_F_MODE] ? CL_BIT : CL_BT;
      else if (op[2:0] == 3'h1)
         classOf = CL_JMP;
      else if (op[2:0] == 3'h7)
         classOf = (op[7:5] > 3'h5) ? CL_NOP : CL_ALU;
      else
         classOf = op[`MCB_F_MODE] ? CL_SD : CL_INH;
   endfunction

   function automatic logic relCond(input logic [1:0] t,
                                    input logic z, input logic c);
      case (t)
         2'h0:    relCond = !z;
         2'h1:    relCond = !c;
         2'h2:    relCond = z;
         default: relCond = c;
      endcase
   endfunction

   // pins are asynchronous to the core clock
   always_ff @(posedge clock) begin
      if (!nrst) begin
         syncMeta <= 3'h0;
         syncOut  <= 3'h0;
      end else begin
         syncMeta <= {irqReq, wakeReq, wdgOption};
         syncOut  <= syncMeta;
      end
   end
   assign wdgS  = syncOut[0];
   assign wakeS = syncOut[1];
   assign irqS  = syncOut[2];

   assign cls      = classOf(opcode);
   assign fetchCls = classOf(pmData);
   assign irqTake  = (state == S_FETCH) && irqS && !inIrq;
   assign isImm    = opcode[`MCB_F_MODE] && opcode[`MCB_F_PTRSEL];
   assign isIncDec = (cls == CL_SD) ||
                     (cls == CL_ALU && opcode[7:6] == 2'h2);
   // bit number sits reversed in opcode bits 7..5
   assign bitSel   = {opcode[5], opcode[6], opcode[7]};
   assign bitMask  = 8'h01 << bitSel;
   assign sext5    = {{7{opcode[7]}}, opcode[7:3]};
   assign sext8    = {{4{byte3[7]}}, byte3};
   assign jmpTgt   = {opcode[7:4], byte2};
   assign btTaken  = (tbit == opcode[`MCB_F_BITSET]);
   assign spDec    = (sp == 3'h0) ? `MCB_STK_LAST : sp - 3'h1;
   assign pmAddr   = pc;
   assign accOut   = acc;

   always_comb begin
      aluOp = A_PASS;
      if (cls == CL_ALU) begin
         case (opcode[7:5])
            3'h0:    aluOp = A_ADD;
            3'h1:    aluOp = A_AND;
            3'h2,
            3'h3:    aluOp = A_SUB;
            3'h4:    aluOp = A_INC;
            default: aluOp = A_DEC;
         endcase
      end else if (cls == CL_SD) begin
         aluOp = opcode[4] ? A_DEC : A_INC;
      end else if (cls == CL_INH) begin
         case (opcode[7:4])
            `MCB_INH_COM: aluOp = A_COM;
            `MCB_INH_RLC: aluOp = A_RLC;
            `MCB_INH_SLA: aluOp = A_SLA;
            default:      aluOp = A_PASS;
         endcase
      end
   end

   // immediate operand comes from the second byte, else data space
   assign aluB = (cls == CL_ALU && isImm) ? byte2 : dsRdData;

   mcb_alu u_alu (
      .op  (aluOp),
      .a   (acc),
      .b   (aluB),
      .cin (flagC),
      .y   (aluY),
      .z   (aluZ),
      .c   (aluC)
   );

   always_comb begin
      dsAddr = 8'h00;
      if (state == S_BYTE2 && cls == CL_ALU && !opcode[`MCB_F_MODE])
         dsAddr = `MCB_PTR_BASE | {7'h00, opcode[`MCB_F_PTRSEL]};
      else if (state == S_OPER || state == S_EXEC)
         dsAddr = byte2;
   end

   assign dsWe = (state == S_EXEC) && (cls == CL_BIT ||
                 (isIncDec && !(cls == CL_ALU && isImm)));

   always_ff @(posedge clock) begin
      if (!nrst) begin
         state    <= S_FETCH;
         stopMode <= 1'b0;
         waitMode <= 1'b0;
      end else begin
         case (state)
            S_FETCH: begin
               if (!irqTake) begin
                  if (fetchCls == CL_REL || fetchCls == CL_INH ||
                      fetchCls == CL_NOP)
                     state <= S_EXEC;
                  else
                     state <= S_BYTE2;
               end
            end
            S_BYTE2: state <= S_OPER;
            S_OPER:  state <= (cls == CL_BT) ? S_BYTE3 : S_EXEC;
            S_BYTE3: state <= S_EXEC;
            S_EXEC: begin
               state <= S_FETCH;
               if (cls == CL_INH) begin
                  if (opcode[7:4] == `MCB_INH_STOP) begin
                     state    <= S_HALT;
                     // watchdog keeps running, so stop becomes wait
                     stopMode <= !wdgS;
                     waitMode <= wdgS;
                  end else if (opcode[7:4] == `MCB_INH_WAIT) begin
                     state    <= S_HALT;
                     waitMode <= 1'b1;
                  end
               end
            end
            S_HALT: begin
               if (wakeS || irqS) begin
                  state    <= S_FETCH;
                  stopMode <= 1'b0;
                  waitMode <= 1'b0;
               end
            end
            default: state <= S_FETCH;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         pc      <= `MCB_RST_PC;
         instrPc <= `MCB_RST_PC;
         sp      <= 3'h0;
         inIrq   <= 1'b0;
      end else begin
         case (state)
            S_FETCH: begin
               if (irqTake) begin
                  stk[sp] <= pc;
                  sp      <= (sp == `MCB_STK_LAST) ? 3'h0 : sp + 3'h1;
                  pc      <= irqVector;
                  inIrq   <= 1'b1;
               end else begin
                  instrPc <= pc;
                  pc      <= pc + 12'h001;
               end
            end
            S_BYTE2: begin
               if (!(cls == CL_ALU && !opcode[`MCB_F_MODE]) &&
                   cls != CL_SD)
                  pc <= pc + 12'h001;
            end
            S_BYTE3: pc <= pc + 12'h001;
            S_EXEC: begin
               if (cls == CL_REL && relCond(opcode[2:1], flagZ, flagC))
                  pc <= instrPc + `MCB_REL_BIAS + sext5;
               else if (cls == CL_BT && btTaken)
                  pc <= instrPc + `MCB_BT_BIAS + sext8;
               else if (cls == CL_JMP) begin
                  if (!opcode[`MCB_F_MODE]) begin
                     stk[sp] <= pc;
                     sp <= (sp == `MCB_STK_LAST) ? 3'h0 : sp + 3'h1;
                  end
                  pc <= jmpTgt;
               end else if (cls == CL_INH &&
                            (opcode[7:4] == `MCB_INH_RET ||
                             opcode[7:4] == `MCB_INH_RETURN_FROM_INTERRUPT)) begin
                  sp <= spDec;
                  pc <= stk[spDec];
                  if (opcode[7:4] == `MCB_INH_RETURN_FROM_INTERRUPT)
                     inIrq <= 1'b0;
               end
            end
            default: pc <= pc;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         opcode   <= 8'h00;
         byte2    <= 8'h00;
         byte3    <= 8'h00;
         tbit     <= 1'b0;
         dsWrData <= 8'h00;
         resZ     <= 1'b0;
         resC     <= 1'b0;
      end else begin
         if (state == S_FETCH && !irqTake)
            opcode <= pmData;
         if (state == S_BYTE2) begin
            if (cls == CL_ALU && !opcode[`MCB_F_MODE])
               byte2 <= dsRdData;
            else if (cls == CL_SD)
               byte2 <= `MCB_PTR_BASE | {6'h00, opcode[6:5]};
            else
               byte2 <= pmData;
         end
         if (state == S_BYTE3)
            byte3 <= pmData;
         if (state == S_OPER) begin
            tbit <= |(dsRdData & bitMask);
            resZ <= aluZ;
            resC <= aluC;
            if (cls == CL_BIT)
               dsWrData <= opcode[`MCB_F_BITSET] ?
                           (dsRdData | bitMask) : (dsRdData & ~bitMask);
            else
               dsWrData <= aluY;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         acc    <= 8'h00;
         flagZ  <= 1'b0;
         flagC  <= 1'b0;
         savedZ <= 1'b0;
         savedC <= 1'b0;
      end else if (irqTake) begin
         savedZ <= flagZ;
         savedC <= flagC;
      end else if (state == S_EXEC) begin
         case (cls)
            CL_ALU: begin
               flagZ <= resZ;
               if (!isIncDec)
                  flagC <= resC;
               if (!isIncDec && opcode[7:5] != 3'h2)
                  acc <= dsWrData;
            end
            CL_SD:  flagZ <= resZ;
            CL_BT:  flagC <= tbit;
            CL_INH: begin
               if (aluOp != A_PASS) begin
                  acc   <= aluY;
                  flagZ <= aluZ;
                  flagC <= aluC;
               end else if (opcode[7:4] == `MCB_INH_RETURN_FROM_INTERRUPT) begin
                  flagZ <= savedZ;
                  flagC <= savedC;
               end
            end
            default: acc <= acc;
         endcase
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);

   sequence seqRelFetch;
      state == S_FETCH && !irqTake && fetchCls == CL_REL;
   endsequence
   sequence seqBtFetch;
      state == S_FETCH && !irqTake && fetchCls == CL_BT;
   endsequence
   sequence seqBitFetch;
      state == S_FETCH && !irqTake && fetchCls == CL_BIT;
   endsequence
   sequence seqBtSteps;
      state == S_BYTE2 ##1 state == S_OPER ##1 state == S_BYTE3
      ##1 state == S_EXEC ##1 state == S_FETCH;
   endsequence

   AST_REL_TWO: assert property (
      seqRelFetch |=> state == S_EXEC ##1 state == S_FETCH)
      else $error("short branch not two cycles");
   AST_REL_TGT: assert property (
      state == S_EXEC && cls == CL_REL
      && relCond(opcode[2:1], flagZ, flagC)
      |=> pc == $past(instrPc) + 12'h001 + $past(sext5)
          && $stable(flagZ) && $stable(flagC))
      else $error("short branch target or flags wrong");
   AST_BT_FIVE: assert property (
      seqBtFetch |=> seqBtSteps)
      else $error("bit test branch not five cycles");
   AST_BT_CARRY: assert property (
      state == S_EXEC && cls == CL_BT
      |=> flagC == $past(tbit) && $stable(flagZ))
      else $error("tested bit not copied to carry");
   AST_BT_TGT: assert property (
      state == S_EXEC && cls == CL_BT && btTaken
      |=> pc == $past(instrPc) + 12'h002 + $past(sext8))
      else $error("bit test branch target wrong");
   AST_BIT_FOUR: assert property (
      seqBitFetch |=> ##2 (dsWe && state == S_EXEC
      && dsWrData[bitSel] == opcode[4]) ##1 state == S_FETCH
      && $stable(flagZ) && $stable(flagC))
      else $error("bit set or clear wrong");
   AST_STOP_WDG: assert property (
      state == S_EXEC && cls == CL_INH && opcode[7:4] == 4'h3 && wdgS
      |=> waitMode && !stopMode)
      else $error("stop not turned into wait");
   AST_INCDEC: assert property (
      state == S_EXEC && cls == CL_SD
      |=> $stable(flagC) && flagZ == ($past(dsWrData) == 8'h00))
      else $error("increment flags wrong");
   AST_PTR_SEL: assert property (
      state == S_BYTE2 && cls == CL_ALU && !opcode[3]
      |-> dsAddr == {7'h40, opcode[4]})
      else $error("pointer register not chosen by bit 4");
   AST_ACC_ONLY: assert property (
      state == S_EXEC && cls == CL_INH && opcode[7:4] == `MCB_INH_COM
      |-> !dsWe ##1 acc == ~$past(acc) && flagZ == (acc == 8'h00))
      else $error("invert missed the accumulator or wrote data space");
   AST_RLC_CARRY: assert property (
      state == S_EXEC && cls == CL_INH && opcode[7:4] == `MCB_INH_RLC
      |=> flagC == $past(acc[7])
          && acc == {$past(acc[6:0]), $past(flagC)})
      else $error("rotate through carry wrong");
   AST_JMP_TGT: assert property (
      state == S_EXEC && cls == CL_JMP |=> pc == $past(jmpTgt))
      else $error("long jump target wrong");
endmodule

// ### tb/mcb_mem_model.sv
/* mcb_mem_model: program memory and data space facing the core.
   assumes: both answer combinationally; writes land at the edge. */
module mcb_mem_model (
   input  wire logic        clock,
   input  wire logic [11:0] pmAddr,
   output logic      [7:0]  pmData,
   input  wire logic [7:0]  dsAddr,
   output logic      [7:0]  dsRdData,
   input  wire logic [7:0]  dsWrData,
   input  wire logic        dsWe
);
   timeunit 1ns;
   timeprecision 1ns;
   // loaded and inspected by the bench through hierarchy
   logic [7:0] prog [4096];
   logic [7:0] data [256];
   assign pmData   = prog[pmAddr];
   assign dsRdData = data[dsAddr];
   always @(posedge clock) begin
      if (dsWe === 1'b1)
         data[dsAddr] <= dsWrData;
   end
endmodule

// ### tb/mcb_exec_unit_tb_top.sv
/* mcb_exec_unit_tb_top: self-checking bench for the execution block.
   assumes: mcb_mem_model holds program and data; one 50 MHz clock. */
module mcb_exec_unit_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock = 1'b0;
   logic        nrst = 1'b0;
   logic        wdgOption = 1'b0;
   logic        wakeReq = 1'b0;
   logic        irqReq = 1'b0;
   logic [11:0] irqVector = 12'h000;
   logic [11:0] pmAddr;
   logic [7:0]  pmData;
   logic [7:0]  dsAddr;
   logic [7:0]  dsRdData;
   logic [7:0]  dsWrData;
   logic        dsWe;
   logic [7:0]  accOut;
   logic        flagZ;
   logic        flagC;
   logic        stopMode;
   logic        waitMode;
   logic        inIrq;
   int          failures = 0;
   int          checked = 0;
   int          cycleCount = 0;

   mcb_exec_unit dut (
      .clock(clock), .nrst(nrst), .pmAddr(pmAddr), .pmData(pmData),
      .dsAddr(dsAddr), .dsRdData(dsRdData), .dsWrData(dsWrData),
      .dsWe(dsWe), .wdgOption(wdgOption), .wakeReq(wakeReq),
      .irqReq(irqReq), .irqVector(irqVector), .accOut(accOut),
      .flagZ(flagZ), .flagC(flagC), .stopMode(stopMode),
      .waitMode(waitMode), .inIrq(inIrq));

   mcb_mem_model mem (
      .clock(clock), .pmAddr(pmAddr), .pmData(pmData), .dsAddr(dsAddr),
      .dsRdData(dsRdData), .dsWrData(dsWrData), .dsWe(dsWe));

   always #10 clock = ~clock;

   task automatic finish_test;
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // whole run needs under 2000 cycles; a hang is cut off here
   always @(posedge clock) begin
      cycleCount++;
      if (cycleCount == 5000) begin
         failures++;
         finish_test();
      end
   end

   task automatic chk(input string what, input logic [11:0] exp,
                      input logic [11:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic prep;
      @(negedge clock);
      nrst = 1'b0;
      wdgOption = 1'b0;
      for (int i = 0; i < 4096; i++)
         mem.prog[i] = 8'h05;
      for (int i = 0; i < 256; i++)
         mem.data[i] = 8'h00;
      repeat (3) @(negedge clock);
   endtask

   task automatic put(input logic [11:0] a, input logic [7:0] q[$]);
      foreach (q[i])
         mem.prog[a + 12'(i)] = q[i];
   endtask

   // counts edges from reset release until the core fetches at tgt
   task automatic run_to(input logic [11:0] tgt, input int exp,
                         input string what);
      int n;
      n = 0;
      nrst = 1'b1;
      while (pmAddr !== tgt && n < 200) begin
         @(negedge clock);
         n++;
      end
      chk(what, 12'(exp), 12'(n));
   endtask

   function automatic logic pick(input int w);
      if (w == 0)
         return inIrq;
      if (w == 1)
         return waitMode;
      return stopMode | waitMode;
   endfunction

   task automatic await(input int w, input logic v, input string what);
      int n;
      n = 0;
      while (pick(w) !== v && n < 40) begin
         @(negedge clock);
         n++;
      end
      chk(what, 12'(v), 12'(pick(w)));
   endtask

   function automatic logic [7:0] bitop(input logic sel, input logic tst,
                                        input int n);
      return {n[0], n[1], n[2], sel, ~tst, 3'b011};
   endfunction

   task automatic test_alu;
      prep();
      mem.data[8'h80] = 8'h40;
      mem.data[8'h81] = 8'h41;
      mem.data[8'h40] = 8'h03;
      mem.data[8'h41] = 8'h05;
      mem.data[8'h20] = 8'hff;
      mem.data[8'h82] = 8'h02;
      put(12'h000, {8'h1f, 8'h7f, 8'h07, 8'h17, 8'h3f, 8'h0f, 8'h0f, 8'h20,
                    8'h7f, 8'h06, 8'h5f, 8'h01, 8'h5d, 8'h8f, 8'h20});
      put(12'h00f, {8'h89, 8'h00});
      run_to(12'h800, 40, "alu cycles");
      chk("acc", 12'h000, 12'(accOut));
      chk("alu flags", 12'h003, {10'h0, flagZ, flagC});
      chk("inc mem", 12'h000, 12'(mem.data[8'h20]));
      chk("dec reg", 12'h001, 12'(mem.data[8'h82]));
      $display("alu test done");
   endtask

   // 7f inverts to 80, shifts out to 00, carry rotates back in as 01
   task automatic test_accum;
      prep();
      put(12'h000, {8'h1f, 8'h7f, 8'h55, 8'h75, 8'h65, 8'hc7, 8'h89,
                    8'h00});
      run_to(12'h800, 16, "accum cycles");
      chk("accum", 12'h001, 12'(accOut));
      chk("accum flags", 12'h000, {10'h0, flagZ, flagC});
      $display("accumulator test done");
   endtask

   task automatic test_branch;
      logic [7:0] op;
      logic       tk;
      for (int s = 0; s < 2; s++) begin
         for (int c = 0; c < 4; c++) begin
            prep();
            // set 0 leaves Z clear and C set, set 1 the reverse
            tk = (c == 0 || c == 3) ? (s == 0) : (s == 1);
            op = {(s == 0) ? 5'h0f : 5'h10, 2'(c), 1'b0};
            put(12'h000, {8'h19, 8'h00});
            put(12'h100, {(s == 0) ? 8'h5f : 8'h1f, 8'(s == 0), op});
            put(12'h103, {8'h99, 8'h00});
            put((s == 0) ? 12'h112 : 12'h0f3, {8'h89, 8'h00});
            run_to(tk ? 12'h800 : 12'h900, 14, "branch");
            chk("branch Z", 12'(s), 12'(flagZ));
            chk("branch C", 12'(1 - s), 12'(flagC));
         end
      end
      $display("branch test done");
   endtask

   task automatic test_bitset;
      logic [7:0] a;
      prep();
      put(12'h000, {8'h5f, 8'h01});
      for (int n = 0; n < 8; n++) begin
         a = 8'(n * 36);
         mem.data[~a] = 8'hff;
         put(12'(2 + 4 * n), {bitop(1'b1, 1'b0, n), a,
                              bitop(1'b0, 1'b0, n), ~a});
      end
      put(12'h022, {8'h89, 8'h00});
      run_to(12'h800, 72, "bit op cycles");
      for (int n = 0; n < 8; n++) begin
         a = 8'(n * 36);
         chk("set", 12'(1 << n), 12'(mem.data[a]));
         chk("clr", 12'(255 ^ (1 << n)), 12'(mem.data[~a]));
      end
      chk("bit op flags", 12'h001, {10'h0, flagZ, flagC});
      $display("bit op test done");
   endtask

   task automatic test_bittest;
      for (int k = 0; k < 4; k++) begin
         prep();
         // k bit 0 picks the set variant, k bit 1 the tested value
         mem.data[8'h55] = k[1] ? 8'h01 << (k + 2) : ~(8'h01 << (k + 2));
         put(12'h000, {8'h19, 8'h00});
         put(12'h100, {k[1] ? 8'h1f : 8'h5f, 8'(!k[1])});
         put(12'h102, {bitop(k[0], 1'b1, k + 2), 8'h55,
                       k[0] ? 8'h7f : 8'h80});
         put(12'h183, {8'h89, 8'h00});
         put(12'h084, {8'h89, 8'h00});
         put(12'h105, {8'h99, 8'h00});
         run_to((k[0] == k[1]) ? 12'h800 : 12'h900, 17,
                "bit test");
         chk("bit test C", 12'(k[1]), 12'(flagC));
         chk("bit test Z", 12'(k[1]), 12'(flagZ));
      end
      $display("bit test done");
   endtask

   task automatic test_call_irq;
      prep();
      put(12'h000, {8'h5f, 8'h01, 8'ha1, 8'h55, 8'h89, 8'h00});
      put(12'ha55, {8'h15});
      put(12'h700, {8'h1f, 8'h00, 8'h25});
      irqVector = 12'h700;
      run_to(12'h800, 14, "call ret");
      chk("ret flags", 12'h001, {10'h0, flagZ, flagC});
      irqReq = 1'b1;
      await(0, 1'b1, "irq entry");
      irqReq = 1'b0;
      await(0, 1'b0, "irq return");
      chk("return_from_interrupt flags", 12'h001, {10'h0, flagZ, flagC});
      $display("call and interrupt test done");
   endtask

   task automatic wake;
      logic [11:0] p;
      p = pmAddr;
      repeat (5) @(negedge clock);
      chk("halt pc", p, pmAddr);
      wakeReq = 1'b1;
      await(2, 1'b0, "wake");
      wakeReq = 1'b0;
   endtask

   task automatic test_halt;
      prep();
      put(12'h000, {8'h45, 8'h05, 8'h05, 8'h05, 8'h35, 8'h05, 8'h05});
      put(12'h007, {8'h05, 8'h35, 8'h05, 8'h05, 8'h05, 8'h89, 8'h00});
      nrst = 1'b1;
      repeat (2) @(negedge clock);
      chk("wait mode", 12'h001, {10'h0, stopMode, waitMode});
      wake();
      await(2, 1'b1, "stop entry");
      chk("stop mode", 12'h002, {10'h0, stopMode, waitMode});
      wdgOption = 1'b1;
      wake();
      await(2, 1'b1, "guarded stop");
      chk("stop as wait", 12'h001, {10'h0, stopMode, waitMode});
      wake();
      $display("halt test done");
   endtask

   initial begin
      repeat (20) @(negedge clock);
      test_alu();
      test_accum();
      test_branch();
      test_bitset();
      test_bittest();
      test_call_irq();
      test_halt();
      finish_test();
   end
endmodule
